//--- rtl/scsl_pkg.sv
// constants for the serial connection start logic: register map, mode
// field layout, reset values and the characters the block recognises.
// assumes a byte-wide serial stream and a word-wide register port.
package scsl_pkg;
  localparam int ADDR_W = 8;
  localparam int HL_MAX = 12;
  localparam int HL_IDX_W = 4;
  // register offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_START_CHAR = 8'h04;
  localparam logic [7:0] OFS_REM_IP = 8'h08;
  localparam logic [7:0] OFS_REM_PORT = 8'h0C;
  localparam logic [7:0] OFS_RETRY = 8'h10;
  localparam logic [7:0] OFS_HL_COUNT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [1:0] HL_IP_PAGE = 2'h1;
  localparam logic [1:0] HL_PORT_PAGE = 2'h2;
  // reset values
  localparam logic [7:0] MODE_RST = 8'hC0;
  localparam logic [7:0] START_CHAR_RST = 8'h0D;
  localparam logic [3:0] RETRY_RST = 4'h3;
  // mode byte layout
  localparam int MODE_RESP_BIT = 4;
  localparam logic [3:0] ST_NONE = 4'h0;
  localparam logic [3:0] ST_ANY = 4'h1;
  localparam logic [3:0] ST_LINE = 4'h2;
  localparam logic [3:0] ST_CHAR = 4'h3;
  localparam logic [3:0] ST_MANUAL = 4'h4;
  localparam logic [3:0] ST_AUTO = 4'h5;
  localparam logic [3:0] ST_MODEM_A = 4'h6;
  localparam logic [3:0] ST_MODEM_B = 4'h7;
  localparam logic [3:0] HOSTLIST_PAT = 4'h2;
  // status register fields
  localparam int STS_CONN_BIT = 0;
  localparam int STS_BUSY_BIT = 1;
  localparam int STS_WALK_BIT = 2;
  localparam int STS_IDX_LSB = 4;
  localparam int STS_TRY_LSB = 8;
  // characters and numeric field limits
  localparam logic [7:0] CH_CMD = 8'h43;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] RSP_CONN = 8'h43;
  localparam logic [7:0] RSP_DISC = 8'h44;
  localparam logic [7:0] RSP_UNREACH = 8'h4E;
  localparam logic [16:0] OCTET_MAX = 17'h000FF;
  localparam logic [16:0] PORT_MAX = 17'h0FFFF;
endpackage

//--- rtl/scsl_cmd_parse.sv
// manual connection command parser: C<address>[/<port>] ended by CR or LF.
// assumes one character per in_valid pulse; en low drops any partial command.
`timescale 1ns/10ps
module scsl_cmd_parse (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic [31:0] base_ip,
  input wire logic [15:0] base_port,
  output logic done_ff,
  output logic monitor_ff,
  output logic [31:0] ip_ff,
  output logic [15:0] port_ff
);
  typedef enum logic [1:0] {PS_IDLE, PS_ADDR, PS_PORT, PS_BAD} scsl_ps_t;
  scsl_ps_t ps_ff, nxt_ps;
  logic [16:0] acc_ff, nxt_acc;
  logic big_ff, nxt_big, dig_ff, nxt_dig, nxt_done, nxt_mon;
  logic [2:0] oct_ff, nxt_oct;
  logic [31:0] ipacc_ff, nxt_ipacc, cl_ip, mask, nxt_ip;
  logic [15:0] nxt_port;
  logic [20:0] mul;
  logic is_dig, is_end, cl_ok;

  // field close checks, accumulator step and address merge
  always_comb begin
    is_dig = (in_data >= scsl_pkg::CH_ZERO) && (in_data <= scsl_pkg::CH_NINE);
    is_end = (in_data == scsl_pkg::CH_CR) || (in_data == scsl_pkg::CH_LF);
    mul = {acc_ff, 3'b000} + {2'b00, acc_ff, 1'b0} + {13'h0000, in_data - scsl_pkg::CH_ZERO};
    cl_ok = dig_ff && !big_ff && (acc_ff <= scsl_pkg::OCTET_MAX) && (oct_ff != 3'h4);
    cl_ip = {ipacc_ff[23:0], acc_ff[7:0]};
    // partial address only replaces the low octets; past the slash the
    // last octet is already counted in oct_ff
    unique case ((ps_ff == PS_PORT) ? oct_ff - 3'h1 : oct_ff)
      3'h0: mask = 32'h000000FF;
      3'h1: mask = 32'h0000FFFF;
      3'h2: mask = 32'h00FFFFFF;
      default: mask = 32'hFFFFFFFF;
    endcase
    nxt_ip = (base_ip & ~mask) | (cl_ip & mask);
    nxt_ps = ps_ff;
    nxt_acc = acc_ff;
    nxt_big = big_ff;
    nxt_dig = dig_ff;
    nxt_oct = oct_ff;
    nxt_ipacc = ipacc_ff;
    nxt_done = 1'b0;
    nxt_mon = 1'b0;
    nxt_port = port_ff;
    if (!en) begin
      nxt_ps = PS_IDLE;
    end else if (in_valid) begin
      unique case (ps_ff)
        PS_IDLE: begin
          if (in_data == scsl_pkg::CH_CMD) begin
            nxt_ps = PS_ADDR;
            nxt_acc = '0;
            nxt_big = 1'b0;
            nxt_dig = 1'b0;
            nxt_oct = '0;
            nxt_ipacc = '0;
          end
        end
        PS_ADDR, PS_PORT: begin
          if (is_dig) begin
            nxt_acc = mul[16:0];
            nxt_big = big_ff || (mul > {4'h0, scsl_pkg::PORT_MAX});
            nxt_dig = 1'b1;
          end else if (ps_ff == PS_ADDR && in_data == scsl_pkg::CH_DOT) begin
            nxt_ps = (cl_ok && oct_ff != 3'h3) ? PS_ADDR : PS_BAD;
            nxt_ipacc = cl_ip;
            nxt_oct = oct_ff + 3'h1;
            nxt_acc = '0;
            nxt_dig = 1'b0;
          end else if (ps_ff == PS_ADDR && in_data == scsl_pkg::CH_SLASH) begin
            nxt_ps = cl_ok ? PS_PORT : PS_BAD;
            nxt_ipacc = cl_ip;
            nxt_oct = oct_ff + 3'h1;
            nxt_acc = '0;
            nxt_dig = 1'b0;
          end else if (is_end && ps_ff == PS_ADDR) begin
            nxt_ps = PS_IDLE;
            nxt_done = cl_ok;
            nxt_ipacc = cl_ip;
            nxt_oct = oct_ff + 3'h1;
            nxt_port = base_port;
          end else if (is_end) begin
            // port 0 is only legal as the monitor request
            nxt_ps = PS_IDLE;
            nxt_mon = dig_ff && !big_ff && acc_ff == '0 && oct_ff == 3'h4
                      && ipacc_ff == '0;
            nxt_done = dig_ff && !big_ff && (acc_ff != '0 || nxt_mon);
            nxt_port = acc_ff[15:0];
          end else begin
            nxt_ps = PS_BAD;
          end
        end
        PS_BAD: begin
          if (is_end) begin
            nxt_ps = PS_IDLE;
          end
        end
      endcase
    end
  end

  // parser state registers; ip_ff holds the merged address
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ps_ff <= PS_IDLE;
      acc_ff <= '0;
      big_ff <= 1'b0;
      dig_ff <= 1'b0;
      oct_ff <= '0;
      ipacc_ff <= '0;
      done_ff <= 1'b0;
      monitor_ff <= 1'b0;
      ip_ff <= '0;
      port_ff <= '0;
    end else begin
      ps_ff <= nxt_ps;
      acc_ff <= nxt_acc;
      big_ff <= nxt_big;
      dig_ff <= nxt_dig;
      oct_ff <= nxt_oct;
      ipacc_ff <= nxt_ipacc;
      done_ff <= nxt_done;
      monitor_ff <= nxt_mon;
      port_ff <= nxt_port;
      if (ps_ff == PS_ADDR && in_valid && is_end) begin
        ip_ff <= nxt_ip;
      end else if (ps_ff == PS_PORT && in_valid && is_end) begin
        ip_ff <= (base_ip & ~mask) | (ipacc_ff & mask);
      end
    end
  end
endmodule // scsl_cmd_parse

//--- rtl/scsl_start.sv
// serial connection start logic: decides when to ask the network engine
// for an outgoing connection and reports state changes as characters.
// assumes the engine answers every request with exactly one of
// conn_up/conn_fail, and conn_down only after conn_up; tx never stalls.
`timescale 1ns/10ps
module scsl_start #(
  parameter int HL_DEPTH = scsl_pkg::HL_MAX
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [scsl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic hs_line,
  input wire logic boot_done,
  input wire logic conn_up,
  input wire logic conn_fail,
  input wire logic conn_down,
  output logic conn_req_ff,
  output logic [31:0] conn_ip_ff,
  output logic [15:0] conn_port_ff,
  output logic monitor_req_ff,
  output logic refuse_incoming_ff,
  output logic tx_valid_ff,
  output logic [7:0] tx_data_ff
);
  typedef enum logic [1:0] {LK_IDLE, LK_WAIT, LK_UP} scsl_lk_t;
  // software settings
  logic [7:0] link_start_setting_ff, nxt_setting;
  logic [7:0] start_char_ff, nxt_start_char;
  logic [31:0] rem_ip_ff, nxt_rem_ip;
  logic [15:0] rem_port_ff, nxt_rem_port;
  logic [3:0] retry_ff, nxt_retry;
  logic [3:0] hl_cnt_ff, nxt_hl_cnt;
  logic [31:0] hl_ip_mem [HL_DEPTH];
  logic [15:0] hl_port_mem [HL_DEPTH];
  logic [31:0] nxt_rdata;
  logic [3:0] ridx;
  // link control state
  scsl_lk_t lk_ff, nxt_lk;
  logic [3:0] idx_ff, nxt_idx, try_ff, nxt_try, try_lim, idx_inc;
  logic hs_prev_ff, walk_ff, nxt_walk;
  logic nxt_req, nxt_mon, nxt_tx, nxt_refuse;
  logic [31:0] nxt_ip;
  logic [15:0] nxt_port;
  logic [7:0] nxt_tx_data;
  logic [3:0] method;
  logic modem_on, hl_on, resp_on, trig, par_en, par_done, par_mon;
  logic [31:0] par_ip;
  logic [15:0] par_port;

  // decode the mode byte
  always_comb begin
    method = link_start_setting_ff[3:0];
    modem_on = (method == scsl_pkg::ST_MODEM_A) || (method == scsl_pkg::ST_MODEM_B);
    hl_on = (link_start_setting_ff[7:4] == scsl_pkg::HOSTLIST_PAT) && !modem_on
            && (method != scsl_pkg::ST_MANUAL);
    resp_on = link_start_setting_ff[scsl_pkg::MODE_RESP_BIT] && !modem_on
              && !hl_on;
    try_lim = (retry_ff == 4'h0) ? 4'h1 : retry_ff;
    idx_inc = (idx_ff + 4'h1 >= hl_cnt_ff) ? 4'h0 : idx_ff + 4'h1;
    par_en = (method == scsl_pkg::ST_MANUAL) && (lk_ff == LK_IDLE);
  end

  // manual command strings are parsed only while idle in manual mode
  scsl_cmd_parse u_parse (
    .core_clk(core_clk),
    .rst(rst),
    .en(par_en),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .base_ip(rem_ip_ff),
    .base_port(rem_port_ff),
    .done_ff(par_done),
    .monitor_ff(par_mon),
    .ip_ff(par_ip),
    .port_ff(par_port)
  );

  // start triggers for each method
  always_comb begin
    unique case (method)
      scsl_pkg::ST_ANY: trig = rx_valid;
      scsl_pkg::ST_LINE: trig = hs_line && !hs_prev_ff;
      scsl_pkg::ST_CHAR: trig = rx_valid && rx_data == start_char_ff;
      scsl_pkg::ST_MANUAL: trig = par_done && !par_mon;
      scsl_pkg::ST_AUTO: trig = boot_done;
      default: trig = 1'b0;
    endcase
  end

  // register writes; the host list itself is plain storage
  always_comb begin
    nxt_setting = link_start_setting_ff;
    nxt_start_char = start_char_ff;
    nxt_rem_ip = rem_ip_ff;
    nxt_rem_port = rem_port_ff;
    nxt_retry = retry_ff;
    nxt_hl_cnt = hl_cnt_ff;
    if (reg_wr) begin
      unique case (reg_addr)
        scsl_pkg::OFS_MODE: nxt_setting = reg_wdata[7:0];
        scsl_pkg::OFS_START_CHAR: nxt_start_char = reg_wdata[7:0];
        scsl_pkg::OFS_REM_IP: nxt_rem_ip = reg_wdata;
        scsl_pkg::OFS_REM_PORT: nxt_rem_port = reg_wdata[15:0];
        scsl_pkg::OFS_RETRY: nxt_retry = reg_wdata[3:0];
        // count is clamped to what the list can hold
        scsl_pkg::OFS_HL_COUNT: begin
          nxt_hl_cnt = (reg_wdata[3:0] > 4'(HL_DEPTH)) ? 4'(HL_DEPTH) : reg_wdata[3:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_start_setting_ff <= scsl_pkg::MODE_RST;
      start_char_ff <= scsl_pkg::START_CHAR_RST;
      rem_ip_ff <= '0;
      rem_port_ff <= '0;
      retry_ff <= scsl_pkg::RETRY_RST;
      hl_cnt_ff <= '0;
    end else begin
      link_start_setting_ff <= nxt_setting;
      start_char_ff <= nxt_start_char;
      rem_ip_ff <= nxt_rem_ip;
      rem_port_ff <= nxt_rem_port;
      retry_ff <= nxt_retry;
      hl_cnt_ff <= nxt_hl_cnt;
    end
  end

  // host list entries, address page then port page
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < HL_DEPTH; i++) begin
        hl_ip_mem[i] <= '0;
        hl_port_mem[i] <= '0;
      end
    end else if (reg_wr && int'(reg_addr[5:2]) < HL_DEPTH) begin
      if (reg_addr[7:6] == scsl_pkg::HL_IP_PAGE) begin
        hl_ip_mem[reg_addr[5:2]] <= reg_wdata;
      end else if (reg_addr[7:6] == scsl_pkg::HL_PORT_PAGE) begin
        hl_port_mem[reg_addr[5:2]] <= reg_wdata[15:0];
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    ridx = reg_addr[5:2];
    nxt_rdata = '0;
    if (reg_rd) begin
      if (reg_addr[7:6] == scsl_pkg::HL_IP_PAGE && int'(ridx) < HL_DEPTH) begin
        nxt_rdata = hl_ip_mem[ridx];
      end else if (reg_addr[7:6] == scsl_pkg::HL_PORT_PAGE && int'(ridx) < HL_DEPTH) begin
        nxt_rdata = {16'h0000, hl_port_mem[ridx]};
      end else begin
        unique case (reg_addr)
          scsl_pkg::OFS_MODE: nxt_rdata = {24'h000000, link_start_setting_ff};
          scsl_pkg::OFS_START_CHAR: nxt_rdata = {24'h000000, start_char_ff};
          scsl_pkg::OFS_REM_IP: nxt_rdata = rem_ip_ff;
          scsl_pkg::OFS_REM_PORT: nxt_rdata = {16'h0000, rem_port_ff};
          scsl_pkg::OFS_RETRY: nxt_rdata = {28'h0000000, retry_ff};
          scsl_pkg::OFS_HL_COUNT: nxt_rdata = {28'h0000000, hl_cnt_ff};
          scsl_pkg::OFS_STATUS: begin
            nxt_rdata[scsl_pkg::STS_CONN_BIT] = (lk_ff == LK_UP);
            nxt_rdata[scsl_pkg::STS_BUSY_BIT] = (lk_ff != LK_IDLE);
            nxt_rdata[scsl_pkg::STS_WALK_BIT] = walk_ff;
            nxt_rdata[scsl_pkg::STS_IDX_LSB +: 4] = idx_ff;
            nxt_rdata[scsl_pkg::STS_TRY_LSB +: 4] = try_ff;
          end
          default: ;
        endcase
      end
    end
  end

  // connection sequencing, host-list walk and state-change characters
  always_comb begin
    nxt_lk = lk_ff;
    nxt_idx = idx_ff;
    nxt_try = try_ff;
    nxt_walk = walk_ff;
    nxt_req = 1'b0;
    nxt_mon = 1'b0;
    nxt_ip = conn_ip_ff;
    nxt_port = conn_port_ff;
    nxt_tx = 1'b0;
    nxt_tx_data = tx_data_ff;
    nxt_refuse = hl_on;
    unique case (lk_ff)
      LK_IDLE: begin
        if (par_done && par_mon && method == scsl_pkg::ST_MANUAL) begin
          nxt_mon = 1'b1;
        end else if (trig && hl_on) begin
          // an empty list never starts a walk
          if (hl_cnt_ff != 4'h0) begin
            nxt_lk = LK_WAIT;
            nxt_walk = 1'b1;
            nxt_idx = 4'h0;
            nxt_try = 4'h1;
            nxt_req = 1'b1;
            nxt_ip = hl_ip_mem[0];
            nxt_port = hl_port_mem[0];
          end
        end else if (trig) begin
          nxt_lk = LK_WAIT;
          nxt_walk = 1'b0;
          nxt_req = 1'b1;
          nxt_ip = (method == scsl_pkg::ST_MANUAL) ? par_ip : rem_ip_ff;
          nxt_port = (method == scsl_pkg::ST_MANUAL) ? par_port : rem_port_ff;
        end
      end
      LK_WAIT: begin
        if (conn_up) begin
          nxt_lk = LK_UP;
          nxt_tx = resp_on;
          nxt_tx_data = scsl_pkg::RSP_CONN;
        end else if (conn_fail && walk_ff) begin
          // retry the same entry until its count runs out, then move on
          nxt_req = 1'b1;
          if (try_ff >= try_lim) begin
            nxt_idx = idx_inc;
            nxt_try = 4'h1;
            nxt_ip = hl_ip_mem[idx_inc];
            nxt_port = hl_port_mem[idx_inc];
          end else begin
            nxt_try = try_ff + 4'h1;
          end
        end else if (conn_fail) begin
          nxt_lk = LK_IDLE;
          nxt_tx = resp_on;
          nxt_tx_data = scsl_pkg::RSP_UNREACH;
        end
      end
      LK_UP: begin
        if (conn_down) begin
          nxt_lk = LK_IDLE;
          nxt_walk = 1'b0;
          nxt_tx = resp_on;
          nxt_tx_data = scsl_pkg::RSP_DISC;
        end
      end
      default: nxt_lk = LK_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lk_ff <= LK_IDLE;
      idx_ff <= '0;
      try_ff <= '0;
      walk_ff <= 1'b0;
      hs_prev_ff <= 1'b0;
      conn_req_ff <= 1'b0;
      conn_ip_ff <= '0;
      conn_port_ff <= '0;
      monitor_req_ff <= 1'b0;
      refuse_incoming_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_data_ff <= '0;
      reg_rdata_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
      idx_ff <= nxt_idx;
      try_ff <= nxt_try;
      walk_ff <= nxt_walk;
      hs_prev_ff <= hs_line;
      conn_req_ff <= nxt_req;
      conn_ip_ff <= nxt_ip;
      conn_port_ff <= nxt_port;
      monitor_req_ff <= nxt_mon;
      refuse_incoming_ff <= nxt_refuse;
      tx_valid_ff <= nxt_tx;
      tx_data_ff <= nxt_tx_data;
      reg_rdata_ff <= nxt_rdata;
    end
  end
endmodule // scsl_start

//--- verification/scsl_start_asserts.sv
// assertion checker for scsl_start, watching its ports only.
// assumes mode and start character are not rewritten while an attempt is open.
`timescale 1ns/10ps
module scsl_start_chk #(
  parameter int HL_DEPTH = scsl_pkg::HL_MAX
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [scsl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic hs_line,
  input wire logic conn_up,
  input wire logic conn_fail,
  input wire logic conn_down,
  input wire logic conn_req_ff,
  input wire logic refuse_incoming_ff,
  input wire logic tx_valid_ff,
  input wire logic [7:0] tx_data_ff
);
  logic [7:0] mode_ff, nxt_mode, sc_ff, nxt_sc;
  logic [3:0] lo;
  logic hl_on, cr_lf;
  // shadow of mode and start character, so triggers can be tied to settings
  always_comb begin
    nxt_mode = mode_ff;
    nxt_sc = sc_ff;
    if (reg_wr && reg_addr == scsl_pkg::OFS_MODE) nxt_mode = reg_wdata[7:0];
    if (reg_wr && reg_addr == scsl_pkg::OFS_START_CHAR) nxt_sc = reg_wdata[7:0];
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= scsl_pkg::MODE_RST;
      sc_ff <= scsl_pkg::START_CHAR_RST;
    end else begin
      mode_ff <= nxt_mode;
      sc_ff <= nxt_sc;
    end
  end
  // host list needs its pattern and neither manual nor modem startup
  assign lo = mode_ff[3:0];
  assign hl_on = mode_ff[7:4] == scsl_pkg::HOSTLIST_PAT && lo != scsl_pkg::ST_MANUAL
    && lo[3:1] != 3'h3;
  assign cr_lf = rx_valid && (rx_data == scsl_pkg::CH_CR || rx_data == scsl_pkg::CH_LF);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_tx_cause;
    tx_valid_ff |-> $past(conn_up) && tx_data_ff == scsl_pkg::RSP_CONN
      || $past(conn_fail) && tx_data_ff == scsl_pkg::RSP_UNREACH
      || $past(conn_down) && tx_data_ff == scsl_pkg::RSP_DISC;
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("bad state char");
  property p_quiet;
    tx_valid_ff |-> $past(mode_ff[scsl_pkg::MODE_RESP_BIT]) && $past(lo[3:1]) != 3'h3;
  endproperty
  a_quiet: assert property (p_quiet) else $error("char while quiet");
  property p_none;
    conn_req_ff |-> $past(lo) != scsl_pkg::ST_NONE && $past(lo[3:1]) != 3'h3;
  endproperty
  a_none: assert property (p_none) else $error("request with no startup");
  property p_any;
    conn_req_ff && $past(lo) == scsl_pkg::ST_ANY && !$past(hl_on) |-> $past(rx_valid);
  endproperty
  a_any: assert property (p_any) else $error("request without char");
  property p_line;
    conn_req_ff && $past(lo) == scsl_pkg::ST_LINE && !$past(hl_on)
      |-> $past(hs_line) && !$past(hs_line, 2);
  endproperty
  a_line: assert property (p_line) else $error("request without edge");
  property p_char;
    conn_req_ff && $past(lo) == scsl_pkg::ST_CHAR && !$past(hl_on)
      |-> $past(rx_valid) && $past(rx_data) == $past(sc_ff);
  endproperty
  a_char: assert property (p_char) else $error("request without start char");
  property p_manual;
    conn_req_ff && $past(lo) == scsl_pkg::ST_MANUAL |-> $past(cr_lf, 2);
  endproperty
  a_manual: assert property (p_manual) else $error("request without end");
  property p_hl_next;
    hl_on && conn_fail |=> conn_req_ff;
  endproperty
  a_hl_next: assert property (p_hl_next) else $error("host list stalled");
  property p_refuse;
    mode_ff == $past(mode_ff) && mode_ff == $past(mode_ff, 2) |-> refuse_incoming_ff == hl_on;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refuse level wrong");
endmodule // scsl_start_chk
bind scsl_start scsl_start_chk #(.HL_DEPTH(HL_DEPTH)) u_scsl_start_chk (.core_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .rx_valid, .rx_data, .hs_line, .conn_up, .conn_fail,
  .conn_down, .conn_req_ff, .refuse_incoming_ff, .tx_valid_ff, .tx_data_ff);

//--- verification/scsl_eng_model.sv
// behavioural network engine: one answer pulse lat cycles after a request.
// assumes the bench sets lat and fails; drop closes an open link.
`timescale 1ns/10ps
module scsl_eng_model (
  input wire logic core_clk,
  input wire logic conn_req_ff,
  input wire logic drop,
  output logic conn_up,
  output logic conn_fail,
  output logic conn_down
);
  int lat = 2;
  int fails = 1000;
  int cnt = 0;
  logic live = 1'b0;
  initial {conn_up, conn_fail, conn_down} = 3'h0;
  // a single attempt in flight; the first fails attempts are refused
  always @(posedge core_clk) begin
    conn_up <= 1'b0;
    conn_fail <= 1'b0;
    conn_down <= 1'b0;
    if (conn_req_ff) cnt <= lat;
    else if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 1 && fails > 0) begin
      conn_fail <= 1'b1;
      fails <= fails - 1;
    end else if (cnt == 1) begin
      conn_up <= 1'b1;
      live <= 1'b1;
    end
    if (drop && live) begin
      conn_down <= 1'b1;
      live <= 1'b0;
    end
  end
endmodule // scsl_eng_model

//--- verification/tb_top.sv
// self-checking bench for scsl_start with a behavioural network engine.
// assumes the checker binds itself from its own file.
`timescale 1ns/10ps
module tb_top;
  typedef struct {string s; logic [47:0] e; int k;} scsl_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [scsl_pkg::ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic hs_line = 1'b0;
  logic boot_done = 1'b0;
  logic drop = 1'b0;
  logic conn_up, conn_fail, conn_down, conn_req_ff, monitor_req_ff;
  logic refuse_incoming_ff, tx_valid_ff;
  logic [31:0] reg_rdata_ff, conn_ip_ff;
  logic [15:0] conn_port_ff;
  logic [7:0] tx_data_ff;
  logic [47:0] reqs[$];
  logic [7:0] txq[$];
  int num_errors = 0;
  int n_tests = 0;
  int nmon = 0;
  int cyc = 0;
  // stored target 129.1.2.3 port 1234; k: 1 connects, 2 monitor, 0 dropped
  scsl_row_t rows[8] = '{
    '{"C121.2.4.5/1", 48'h7902_0405_0001, 1},
    '{"C5", 48'h8101_0205_04D2, 1},
    '{"C28.10/12", 48'h8101_1C0A_000C, 1},
    '{"C50.1/23", 48'h8101_3201_0017, 1},
    '{"C0.0.0.0/0", 48'h0, 2},
    '{"C1 2", 48'h0, 0},
    '{"C5/70000", 48'h0, 0},
    '{"C5/0", 48'h0, 0}
  };
  scsl_start u_scsl_start (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .rx_valid, .rx_data, .hs_line, .boot_done, .conn_up, .conn_fail,
    .conn_down, .conn_req_ff, .conn_ip_ff, .conn_port_ff, .monitor_req_ff,
    .refuse_incoming_ff, .tx_valid_ff, .tx_data_ff);
  scsl_eng_model eng (.core_clk, .conn_req_ff, .drop, .conn_up, .conn_fail, .conn_down);
  always #2 core_clk = ~core_clk;
  // log requests and characters; the cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (conn_req_ff === 1'b1) reqs.push_back({conn_ip_ff, conn_port_ff});
    if (monitor_req_ff === 1'b1) nmon <= nmon + 1;
    if (tx_valid_ff === 1'b1) txq.push_back(tx_data_ff);
    if (cyc == 3000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int e);
    n_tests++;
    if (g != e) begin
      num_errors++;
      $display("[ERR] %0t count %0d expected %0d", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk({16'h0, reg_rdata_ff}, {16'h0, e});
  endtask
  // characters back to back, then an optional end character
  task automatic send(input string s, input logic [7:0] e);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data <= s[i];
    end
    if (e != 8'h00) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data <= e;
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
  endtask
  task automatic dropit();
    @(posedge core_clk);
    drop <= 1'b1;
    @(posedge core_clk);
    drop <= 1'b0;
  endtask
  task automatic clr();
    reqs.delete();
    txq.delete();
    nmon = 0;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rchk(scsl_pkg::OFS_MODE, 32'hC0);
    rchk(scsl_pkg::OFS_START_CHAR, 32'h0D);
    rchk(scsl_pkg::OFS_RETRY, 32'h3);
    rchk(8'h3C, 32'h0);
    wr(scsl_pkg::OFS_REM_IP, 32'h8101_0203);
    wr(scsl_pkg::OFS_REM_PORT, 32'h04D2);
    // default startup: every trigger is ignored
    clr();
    hs_line <= 1'b1;
    boot_done <= 1'b1;
    send("C5", scsl_pkg::CH_CR);
    hs_line <= 1'b0;
    boot_done <= 1'b0;
    chkn(reqs.size(), 0);
    // manual commands, ends alternating between CR and LF
    wr(scsl_pkg::OFS_MODE, 32'h04);
    foreach (rows[i]) begin
      clr();
      send(rows[i].s, (i % 2) ? scsl_pkg::CH_LF : scsl_pkg::CH_CR);
      repeat (12) @(posedge core_clk);
      chkn(reqs.size(), int'(rows[i].k == 1));
      chkn(nmon, int'(rows[i].k == 2));
      if (rows[i].k == 1) chk(reqs[0], rows[i].e);
    end
    wr(scsl_pkg::OFS_MODE, 32'h01);
    clr();
    send("x", 8'h00);
    repeat (8) @(posedge core_clk);
    chk(reqs[0], 48'h8101_0203_04D2);
    chkn(txq.size(), 0);
    // a held line starts only once; a fresh edge starts again
    wr(scsl_pkg::OFS_MODE, 32'h02);
    clr();
    hs_line <= 1'b1;
    repeat (20) @(posedge core_clk);
    hs_line <= 1'b0;
    repeat (2) @(posedge core_clk);
    hs_line <= 1'b1;
    repeat (10) @(posedge core_clk);
    hs_line <= 1'b0;
    chkn(reqs.size(), 2);
    wr(scsl_pkg::OFS_MODE, 32'h03);
    clr();
    send("AB", 8'h00);
    send("", scsl_pkg::CH_CR);
    repeat (8) @(posedge core_clk);
    wr(scsl_pkg::OFS_START_CHAR, 32'h21);
    send("\015", 8'h21);
    repeat (8) @(posedge core_clk);
    chkn(reqs.size(), 2);
    // unreachable, connected, disconnected
    wr(scsl_pkg::OFS_MODE, 32'h11);
    eng.fails = 1;
    clr();
    send("a", 8'h00);
    repeat (8) @(posedge core_clk);
    send("b", 8'h00);
    repeat (8) @(posedge core_clk);
    dropit();
    repeat (4) @(posedge core_clk);
    chkn(txq.size(), 3);
    chk({24'h0, txq[0], txq[1], txq[2]}, 48'h4E_4344);
    // autostart with a slow engine must not fire twice while waiting
    wr(scsl_pkg::OFS_MODE, 32'h05);
    eng.lat = 20;
    clr();
    boot_done <= 1'b1;
    repeat (40) @(posedge core_clk);
    boot_done <= 1'b0;
    dropit();
    repeat (8) @(posedge core_clk);
    chkn(reqs.size(), 1);
    eng.lat = 2;
    // two entries, two tries each, first three attempts refused
    wr(8'h40, 32'hAC13_0001);
    wr(8'h80, 32'h0017);
    wr(8'h44, 32'hAC13_0002);
    wr(8'h84, 32'h0BB9);
    wr(scsl_pkg::OFS_HL_COUNT, 32'h2);
    wr(scsl_pkg::OFS_RETRY, 32'h2);
    wr(scsl_pkg::OFS_MODE, 32'h21);
    eng.fails = 3;
    clr();
    send("h", 8'h00);
    repeat (30) @(posedge core_clk);
    chkn(reqs.size(), 4);
    chk(reqs[1], 48'hAC13_0001_0017);
    chk(reqs[2], 48'hAC13_0002_0BB9);
    chk({47'h0, refuse_incoming_ff}, 48'h1);
    chkn(txq.size(), 0);
    dropit();
    wr(scsl_pkg::OFS_HL_COUNT, 32'hD);
    rchk(scsl_pkg::OFS_HL_COUNT, 32'hC);
    eng.fails = 1000;
    wr(scsl_pkg::OFS_MODE, 32'h24);
    clr();
    send("C9", scsl_pkg::CH_CR);
    repeat (8) @(posedge core_clk);
    chk(reqs[0], 48'h8101_0209_04D2);
    chk({47'h0, refuse_incoming_ff}, 48'h0);
    // modem emulation settings never start the link
    wr(scsl_pkg::OFS_MODE, 32'hD6);
    send("C7", scsl_pkg::CH_CR);
    repeat (8) @(posedge core_clk);
    chkn(reqs.size(), 1);
    // a second reset in mid-run restores the quiet default
    wr(scsl_pkg::OFS_MODE, 32'h11);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rchk(scsl_pkg::OFS_MODE, 32'hC0);
    close_out();
  end
endmodule // tb_top
